// file: hdl/odm_top.sv
// output dependency matrix for programmable outputs A and B
`timescale 1ns/1ns
`default_nettype none

module odm_top
    import odm_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire odm_cond_t  cond,
    input  wire odm_outs_t  outs,
    input  wire logic       out_a_term1,
    input  wire logic       manual_reset_n,
    output logic            out_a_asserted,
    output logic            out_b_asserted
);

    // ==========================================================
    // address decode
    // unmapped offsets give no index, so writes vanish and reads return zero
    function automatic logic [3:0] odm_index(input logic [7:0] a);
        case (a)
            ODM_OFS_A2_PRIM: odm_index = ODM_IX_A2_PRIM;
            ODM_OFS_A2_SEC:  odm_index = ODM_IX_A2_SEC;
            ODM_OFS_A2_GPO:  odm_index = ODM_IX_A2_GPO;
            ODM_OFS_B1_PRIM: odm_index = ODM_IX_B1_PRIM;
            ODM_OFS_B1_SEC:  odm_index = ODM_IX_B1_SEC;
            ODM_OFS_B1_GPO:  odm_index = ODM_IX_B1_GPO;
            ODM_OFS_B2_PRIM: odm_index = ODM_IX_B2_PRIM;
            ODM_OFS_B2_SEC:  odm_index = ODM_IX_B2_SEC;
            ODM_OFS_B2_GPO:  odm_index = ODM_IX_B2_GPO;
            ODM_OFS_B1_O8:   odm_index = ODM_IX_B1_O8;
            ODM_OFS_T2_O8:   odm_index = ODM_IX_T2_O8;
            ODM_OFS_MR:      odm_index = ODM_IX_MR;
            default:         odm_index = ODM_IX_NONE;
        endcase
    endfunction

    // ==========================================================
    // condition vector in the common bit layout of every term
    // slot 22 is output six for A and output five for B
    function automatic logic [ODM_TERM_W-1:0] odm_ok_vec(
        input odm_cond_t c,
        input odm_outs_t o,
        input logic      other_asserted
    );
        odm_ok_vec = {~o.prog_output_eight,     // 24
                      ~o.prog_output_seven,     // 23
                      ~other_asserted,          // 22
                      ~o.prog_output_four,      // 21
                      ~o.prog_output_three,     // 20
                      ~o.prog_output_two,       // 19
                      ~o.prog_output_one,       // 18
                      c.gpi_ok,                 // 17:14
                      c.sec_ok,                 // 13:8
                      c.wdog_ok,                // 7:6
                      c.prim_ok};               // 5:0
    endfunction

    // ==========================================================
    // select vector from three layout bytes and the output eight bit
    // the small variant has no output eight, so its bit is dropped here
    function automatic logic [ODM_TERM_W-1:0] odm_sel_vec(
        input logic [7:0] prim,
        input logic [7:0] sec,
        input logic [7:0] gpo,
        input logic       o8
    );
        logic [7:0] g;
        g = gpo;
        odm_sel_vec = {o8 & LARGE_VARIANT, g[7:2], g[1:0], sec[7:6], sec[5:0], prim};
    endfunction

    // ==========================================================
    // register file
    logic [7:0] cfg_reg  [ODM_NREG];
    logic [7:0] cfg_next [ODM_NREG];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [3:0] acc_ix;

    // writes land at the next edge; reads are registered one cycle late
    always_comb begin
        acc_ix = odm_index(reg_addr);
        for (int i = 0; i < ODM_NREG; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        if (reg_wr && acc_ix != ODM_IX_NONE) begin
            cfg_next[acc_ix] = reg_wdata;
        end
        rdata_next = rdata_reg;
        if (reg_rd) begin
            rdata_next = (acc_ix == ODM_IX_NONE) ? 8'h00 : cfg_reg[acc_ix];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < ODM_NREG; i++) begin
                cfg_reg[i] <= ODM_REG_RST;
            end
            rdata_reg <= ODM_REG_RST;
        end else begin
            for (int i = 0; i < ODM_NREG; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ==========================================================
    // term selects
    logic [ODM_TERM_W-1:0] sel_a2;
    logic [ODM_TERM_W-1:0] sel_b1;
    logic [ODM_TERM_W-1:0] sel_b2;
    logic [ODM_TERM_W-1:0] ok_a;
    logic [ODM_TERM_W-1:0] ok_b;
    logic                  term_a2;
    logic                  term_b1;
    logic                  term_b2;
    logic                  out_a_reg;
    logic                  out_a_next;
    logic                  out_b_reg;
    logic                  out_b_next;

    // outputs feed back through flops, so A and B never form a loop
    always_comb begin
        sel_a2 = odm_sel_vec(cfg_reg[ODM_IX_A2_PRIM],
                             cfg_reg[ODM_IX_A2_SEC],
                             cfg_reg[ODM_IX_A2_GPO],
                             cfg_reg[ODM_IX_T2_O8][ODM_BIT_A2_O8]);
        sel_b1 = odm_sel_vec(cfg_reg[ODM_IX_B1_PRIM],
                             cfg_reg[ODM_IX_B1_SEC],
                             cfg_reg[ODM_IX_B1_GPO],
                             cfg_reg[ODM_IX_B1_O8][ODM_BIT_B1_O8]);
        sel_b2 = odm_sel_vec(cfg_reg[ODM_IX_B2_PRIM],
                             cfg_reg[ODM_IX_B2_SEC],
                             cfg_reg[ODM_IX_B2_GPO],
                             cfg_reg[ODM_IX_T2_O8][ODM_BIT_B2_O8]);
        ok_a = odm_ok_vec(cond, outs, out_b_reg);  // slot 22 = output six
        ok_b = odm_ok_vec(cond, outs, out_a_reg);  // slot 22 = output five
    end

    odm_term u_term_a2 (
        .sel  (sel_a2),
        .ok   (ok_a),
        .term (term_a2)
    );

    odm_term u_term_b1 (
        .sel  (sel_b1),
        .ok   (ok_b),
        .term (term_b1)
    );

    odm_term u_term_b2 (
        .sel  (sel_b2),
        .ok   (ok_b),
        .term (term_b2)
    );

    // ==========================================================
    // output decision
    // manual reset overrides the terms: a held input keeps the output asserted
    always_comb begin
        out_a_next = ~(out_a_term1 | term_a2);
        if (cfg_reg[ODM_IX_MR][ODM_BIT_MR_A] && !manual_reset_n) begin
            out_a_next = 1'b1;
        end
        out_b_next = ~(term_b1 | term_b2);
        if (cfg_reg[ODM_IX_MR][ODM_BIT_MR_B] && !manual_reset_n) begin
            out_b_next = 1'b1;
        end
    end

    // reset leaves both outputs asserted until the terms are evaluated
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            out_a_reg <= 1'b1;
            out_b_reg <= 1'b1;
        end else begin
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
        end
    end

    assign out_a_asserted = out_a_reg;
    assign out_b_asserted = out_b_reg;

endmodule : odm_top

`default_nettype wire

// file: hdl/odm_pkg.sv
// constants and carrier types for the output dependency matrix
package odm_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ODM_OFS_A2_PRIM = 8'h27;
    localparam logic [7:0] ODM_OFS_A2_SEC  = 8'h28;
    localparam logic [7:0] ODM_OFS_A2_GPO  = 8'h29;
    localparam logic [7:0] ODM_OFS_B1_PRIM = 8'h2B;
    localparam logic [7:0] ODM_OFS_B1_SEC  = 8'h2C;
    localparam logic [7:0] ODM_OFS_B1_GPO  = 8'h2D;
    localparam logic [7:0] ODM_OFS_B2_PRIM = 8'h2E;
    localparam logic [7:0] ODM_OFS_B2_SEC  = 8'h2F;
    localparam logic [7:0] ODM_OFS_B2_GPO  = 8'h30;
    localparam logic [7:0] ODM_OFS_B1_O8   = 8'h31;
    localparam logic [7:0] ODM_OFS_T2_O8   = 8'h3B;
    localparam logic [7:0] ODM_OFS_MR      = 8'h40;

    // ==========================================================
    // storage indices, one byte each
    localparam int ODM_NREG = 12;
    localparam logic [3:0] ODM_IX_A2_PRIM = 4'h0;
    localparam logic [3:0] ODM_IX_A2_SEC  = 4'h1;
    localparam logic [3:0] ODM_IX_A2_GPO  = 4'h2;
    localparam logic [3:0] ODM_IX_B1_PRIM = 4'h3;
    localparam logic [3:0] ODM_IX_B1_SEC  = 4'h4;
    localparam logic [3:0] ODM_IX_B1_GPO  = 4'h5;
    localparam logic [3:0] ODM_IX_B2_PRIM = 4'h6;
    localparam logic [3:0] ODM_IX_B2_SEC  = 4'h7;
    localparam logic [3:0] ODM_IX_B2_GPO  = 4'h8;
    localparam logic [3:0] ODM_IX_B1_O8   = 4'h9;
    localparam logic [3:0] ODM_IX_T2_O8   = 4'hA;
    localparam logic [3:0] ODM_IX_MR      = 4'hB;
    localparam logic [3:0] ODM_IX_NONE    = 4'hF;

    // ==========================================================
    // field positions
    localparam int ODM_BIT_A2_O8 = 4;
    localparam int ODM_BIT_B2_O8 = 5;
    localparam int ODM_BIT_B1_O8 = 0;
    localparam int ODM_BIT_MR_A  = 4;
    localparam int ODM_BIT_MR_B  = 5;
    localparam int ODM_TERM_W    = 25;
    localparam int ODM_BIT_TERM_O8 = 24;

    // ==========================================================
    // reset values
    localparam logic [7:0] ODM_REG_RST = 8'h00;

    // condition levels, 1 = non-fault
    typedef struct packed {
        logic [5:0] prim_ok;
        logic [5:0] sec_ok;
        logic [1:0] wdog_ok;
        logic [3:0] gpi_ok;
    } odm_cond_t;

    // other programmable outputs, 1 = asserted
    typedef struct packed {
        logic prog_output_one;
        logic prog_output_two;
        logic prog_output_three;
        logic prog_output_four;
        logic prog_output_seven;
        logic prog_output_eight;
    } odm_outs_t;

endpackage : odm_pkg

// file: hdl/odm_term.sv
// one product term of the dependency matrix
`timescale 1ns/1ns
`default_nettype none

module odm_term
    import odm_pkg::*;
(
    input  wire logic [ODM_TERM_W-1:0] sel,
    input  wire logic [ODM_TERM_W-1:0] ok,
    output logic                       term
);

    // ==========================================================
    // product
    // a cleared select bit forces its factor to 1
    always_comb begin
        term = &(~sel | ok);
    end

endmodule : odm_term

`default_nettype wire

// file: verification/odm_chk_sva.sv
// concurrent checks on the dependency matrix ports
`timescale 1ns/1ns
`default_nettype none

module odm_chk_sva
    import odm_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire odm_cond_t  cond,
    input wire odm_outs_t  outs,
    input wire logic       out_a_term1,
    input wire logic       manual_reset_n,
    input wire logic       out_a_asserted,
    input wire logic       out_b_asserted
);
    // ====
    // shadow of the select bytes
    logic [7:0]  sh_reg [128];
    logic [7:0]  rd_exp;
    logic [24:0] ok_a, ok_b, sa, sb1, sb2;
    logic        mapped, exp_a_reg, exp_b_reg;

    // outputs are sound while deasserted; slot 22 is fed back from the sibling output
    assign ok_a = {~outs.prog_output_eight, ~outs.prog_output_seven, ~out_b_asserted,
                   ~outs.prog_output_four, ~outs.prog_output_three, ~outs.prog_output_two,
                   ~outs.prog_output_one, cond.gpi_ok, cond.sec_ok, cond.wdog_ok, cond.prim_ok};
    assign ok_b = {ok_a[24:23], ~out_a_asserted, ok_a[21:0]};
    assign mapped = reg_addr inside {8'h27, 8'h28, 8'h29, [8'h2B:8'h31], 8'h3B, 8'h40};
    assign rd_exp = mapped ? sh_reg[reg_addr[6:0]] : 8'h00;
    assign sa  = {sh_reg[7'h3B][4] & LARGE_VARIANT, sh_reg[7'h29], sh_reg[7'h28], sh_reg[7'h27]};
    assign sb1 = {sh_reg[7'h31][0] & LARGE_VARIANT, sh_reg[7'h2D], sh_reg[7'h2C], sh_reg[7'h2B]};
    assign sb2 = {sh_reg[7'h3B][5] & LARGE_VARIANT, sh_reg[7'h30], sh_reg[7'h2F], sh_reg[7'h2E]};

    // expected output state, one edge behind its causes like the outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 128; i++)
                sh_reg[i] <= 8'h00;
            exp_a_reg <= 1'b1;
            exp_b_reg <= 1'b1;
        end else begin
            if (reg_wr && mapped)
                sh_reg[reg_addr[6:0]] <= reg_wdata;
            exp_a_reg <= (sh_reg[7'h40][4] & ~manual_reset_n) | ~(out_a_term1 | &(~sa | ok_a));
            exp_b_reg <= (sh_reg[7'h40][5] & ~manual_reset_n) | ~(&(~sb1 | ok_b) | &(~sb2 | ok_b));
        end
    end

    // ====
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    out_a_terms_a: assert property (out_a_asserted == exp_a_reg)
        else $error("output A differs from its product terms");
    out_b_terms_a: assert property (out_b_asserted == exp_b_reg)
        else $error("output B differs from its product terms");
    mr_force_a_a: assert property (sh_reg[7'h40][4] && !manual_reset_n |=> out_a_asserted)
        else $error("manual reset did not assert output A");
    mr_force_b_a: assert property (sh_reg[7'h40][5] && !manual_reset_n |=> out_b_asserted)
        else $error("manual reset did not assert output B");
    a_term1_free_a: assert property (out_a_term1 && manual_reset_n |=> !out_a_asserted)
        else $error("output A held with term one true");
    b_term2_free_a: assert property (manual_reset_n && sb2 == 25'h0 |=> !out_b_asserted)
        else $error("output B held with empty term two");
    reg_read_a: assert property (reg_rd |=> reg_rdata == $past(rd_exp))
        else $error("read data wrong");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule // odm_chk_sva

`default_nettype wire

// file: verification/odm_top_test.sv
// self-checking bench for the output dependency matrix
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module odm_top_test
    import odm_pkg::*;
;
    // ====
    // stimulus signals
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    odm_cond_t  cond = '1;
    odm_outs_t  outs = '0;
    logic       out_a_term1 = 1'b0;
    logic       manual_reset_n = 1'b1;
    logic       out_a_asserted, out_b_asserted;
    logic       small_a, small_b;
    int         n_fail = 0;
    int         tests_run = 0;
    logic [7:0] ofs [12] = '{8'h27, 8'h28, 8'h29, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h3B, 8'h40};
    logic [7:0] mrv [4] = '{8'h10, 8'h20, 8'hCF, 8'h30};

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    odm_top #(.LARGE_VARIANT(1'b1)) dut_u (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cond, .outs, .out_a_term1, .manual_reset_n, .out_a_asserted, .out_b_asserted);

    // small variant on the same inputs, to see that it ignores output eight
    odm_top #(.LARGE_VARIANT(1'b0)) dut_small_u (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata(), .cond, .outs, .out_a_term1, .manual_reset_n,
        .out_a_asserted(small_a), .out_b_asserted(small_b));

    // ====
    // access tasks; each starts and ends 5 ns after an edge
    task automatic step();
        @(posedge sys_clk);
        #5;
    endtask
    // a strobe stays up between back-to-back accesses, so it is never set twice in one step; ochk drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_rd = 1'b0;
        reg_wr = 1'b1;
        step();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        step();
        `CHK(reg_rdata, e)
    endtask
    // flags from a sound vector in term layout; slot 22 cannot be driven, it is fed back
    task automatic drv(input logic [24:0] ok);
        cond = {ok[5:0], ok[13:8], ok[7:6], ok[17:14]};
        outs = ~{ok[18], ok[19], ok[20], ok[21], ok[23], ok[24]};
    endtask
    // one select vector into A term two and both B terms, so B only asserts if both decode it
    task automatic setall(input logic [24:0] s);
        for (int j = 0; j < 9; j++)
            wr(ofs[j], s[8*(j%3)+:8]);
        wr(8'h31, {7'h00, s[24]});
        wr(8'h3B, {2'b00, s[24], s[24], 4'h0});
    endtask
    task automatic ochk(input logic [1:0] e);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        step();
        `CHK({out_a_asserted, out_b_asserted}, e)
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ====
    // test sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        #5;
        `CHK({out_a_asserted, out_b_asserted}, 2'b11)
        nrst = 1'b1;
        ochk(2'b00);
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        $display("test reset done");
        foreach (ofs[i]) wr(ofs[i], 8'hA5 ^ 8'(i));
        wr(8'h2A, 8'hFF);
        foreach (ofs[i]) rd(ofs[i], 8'hA5 ^ 8'(i));
        rd(8'h2A, 8'h00);
        $display("test registers done");
        // walk one select bit; all other flags faulted must not matter
        for (int k = 0; k < 25; k++) begin
            if (k != 22) begin
                setall(25'h1 << k);
                drv(25'h1 << k);
                ochk(2'b00);
                drv(~(25'h1 << k));
                ochk(2'b11);
                // output eight asserted and selected: the small variant must not follow it
                if (k == 24) `CHK({small_a, small_b}, 2'b00)
            end
        end
        out_a_term1 = 1'b1;
        ochk(2'b01);
        wr(8'h3B, 8'h10);
        ochk(2'b00);
        out_a_term1 = 1'b0;
        drv('1);
        setall('0);
        $display("test select walk done");
        manual_reset_n = 1'b0;
        foreach (mrv[i]) begin
            wr(8'h40, mrv[i]);
            ochk({mrv[i][4], mrv[i][5]});
        end
        wr(8'h40, 8'h00);
        wr(8'h29, 8'h40);
        wr(8'h40, 8'h20);
        ochk(2'b01);
        ochk(2'b11);
        wr(8'h29, 8'h00);
        wr(8'h2D, 8'h40);
        wr(8'h30, 8'h40);
        wr(8'h40, 8'h10);
        ochk(2'b10);
        ochk(2'b11);
        $display("test manual reset done");
        // reset in mid-run drops every select
        nrst = 1'b0;
        step();
        `CHK({out_a_asserted, out_b_asserted}, 2'b11)
        nrst = 1'b1;
        manual_reset_n = 1'b1;
        rd(8'h40, 8'h00);
        ochk(2'b00);
        $display("test second reset done");
        conclude();
    end

    // watchdog, some five times the expected run
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule // odm_top_test

bind odm_top odm_chk_sva #(.LARGE_VARIANT(LARGE_VARIANT)) chk_u (.sys_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cond, .outs, .out_a_term1, .manual_reset_n, .out_a_asserted, .out_b_asserted);

`default_nettype wire
